// file: rtl/tdp_pkg.sv
// Shared constants, types and helpers of the transformer differential protection block
package tdp_pkg;
    localparam int PHASES     = 3;
    localparam int CUR_W      = 16;
    localparam int SET_W      = 8;
    localparam int SCL_W      = 24;
    localparam int PRD_W      = 32;
    localparam int HIST_W     = 16;
    localparam int HIST_DEPTH = 5;
    localparam int IND_W      = 4;
    localparam logic [2:0] IND_IDX = 3'h5;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] TAP_OFS    = 8'h04;
    localparam logic [7:0] RATED_OFS  = 8'h08;
    localparam logic [7:0] HARM_OFS   = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] LED_OFS    = 8'h14;
    localparam logic [7:0] HIST_OFS   = 8'h18;
    localparam logic [7:0] HIST_END   = 8'h28;

    // Control, tap and rated register fields
    localparam int MINOP_LSB = 0;
    localparam int BIAS_LSB  = 2;
    localparam int AUTO_BIT  = 4;
    localparam int IRST_BIT  = 5;
    localparam int LV_LSB    = 8;
    localparam int DOC_LSB   = 8;

    // Values after reset
    localparam logic [1:0]       MINOP_RST = 2'h1;
    localparam logic [1:0]       BIAS_RST  = 2'h2;
    localparam logic             AUTO_RST  = 1'b0;
    localparam logic [SET_W-1:0] TAP_RST   = 8'h32;
    localparam logic [SET_W-1:0] RATED_RST = 8'h32;
    localparam logic [SET_W-1:0] DOC_RST   = 8'h50;
    localparam logic [SET_W-1:0] HARM_RST  = 8'h0f;

    // Percent figures; the overcurrent setting is in tenths of rated current
    localparam logic [6:0] PCT_20   = 7'h14;
    localparam logic [6:0] PCT_30   = 7'h1e;
    localparam logic [6:0] PCT_40   = 7'h28;
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] PCT_HALF = 8'hc8;
    localparam logic [7:0] DOC_DIV  = 8'h0a;

    // Indicator blink half period
    localparam int CLK_HZ    = 20_000_000;
    localparam int BLINK_MS  = 250;
    localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
    localparam int BLINK_W   = 23;

    typedef enum logic [1:0] {RS_WAIT, RS_LOAD, RS_RUN} tdp_restore_e;

    function automatic logic [6:0] tdp_sel_pct(input logic [1:0] code);
        case (code)
            2'h0:    return PCT_20;
            2'h1:    return PCT_30;
            default: return PCT_40;
        endcase
    endfunction
endpackage

// file: rtl/tdp_hist_mem.sv
// Retained store: five fault records, newest first, plus the held indication word
`timescale 1ns/100ps
module tdp_hist_mem (
    // Clock
    input  wire logic                        clock,
    // Record shift-in
    input  wire logic                        shift_en,
    input  wire logic [tdp_pkg::HIST_W-1:0]  shift_data,
    // Indication word
    input  wire logic                        ind_we,
    input  wire logic [tdp_pkg::HIST_W-1:0]  ind_data,
    output logic      [tdp_pkg::HIST_W-1:0]  ind_rd_data,
    // Random read
    input  wire logic [2:0]                  rd_idx,
    output logic      [tdp_pkg::HIST_W-1:0]  rd_data
);
    logic [tdp_pkg::HIST_W-1:0] mem [tdp_pkg::HIST_DEPTH:0];

    // Retained contents take no reset; they start cleared at power-up
    initial begin
        for (int i = 0; i <= tdp_pkg::HIST_DEPTH; i++) begin
            mem[i] = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (shift_en) begin
            for (int i = tdp_pkg::HIST_DEPTH - 1; i > 0; i--) begin
                mem[i] <= mem[i-1];
            end
            mem[0] <= shift_data;
        end
        if (ind_we) begin
            mem[tdp_pkg::HIST_DEPTH] <= ind_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data     <= (rd_idx <= tdp_pkg::IND_IDX) ? mem[rd_idx] : '0;
        ind_rd_data <= mem[tdp_pkg::HIST_DEPTH];
    end
endmodule // tdp_hist_mem

// file: rtl/tdp_top.sv
// Three-phase biased differential protection with harmonic blocking, indicators and history
//
// Contract
// - Every element built separately per phase
// - Scale sides by rated over matching tap
// - Differential is scaled high minus low
// - Restraint is larger scaled side current
// - Ratio times hundred at least bias
// - Differential at least rated times minimum setting
// - Minimum operate selectable 20, 30, 40 percent
// - Bias selectable 20, 30, 40 percent
// - Overcurrent element trips without biased element
// - Harmonic above ratio blocks biased element
// - All-phase lock or segregated per-phase lock
// - All-phase lock only operating, load near zero
// - Load current smaller side, zero below half
// - Yellow lamp: harmonic while biased operating
// - Element lamps light at once on operate
// - Harmonic lamp blinks while ratio exceeds setting
// - Lamps self-hold by default, auto reset optional
// - Held indication kept in retained memory
// - Indicator reset clears held indication
// - Five newest fault records, oldest dropped
//
// The APB register port and the address map were decided locally.
`timescale 1ns/100ps
module tdp_top #(
    parameter int BLINK_CYC = tdp_pkg::BLINK_CYC
) (
    // Clock and reset
    input  wire logic                                       clock,
    input  wire logic                                       rst,
    // APB slave
    input  wire logic                                       psel,
    input  wire logic                                       penable,
    input  wire logic                                       pwrite,
    input  wire logic [7:0]                                 paddr,
    input  wire logic [31:0]                                pwdata,
    output logic      [31:0]                                prdata,
    output logic                                            pready,
    output logic                                            pslverr,
    // Measurement front end
    input  wire logic                                       sample_valid,
    input  wire logic [tdp_pkg::PHASES-1:0][tdp_pkg::CUR_W-1:0] hv_secondary_current,
    input  wire logic [tdp_pkg::PHASES-1:0][tdp_pkg::CUR_W-1:0] lv_secondary_current,
    input  wire logic [tdp_pkg::PHASES-1:0][tdp_pkg::CUR_W-1:0] harm2_mag,
    input  wire logic [tdp_pkg::PHASES-1:0][tdp_pkg::CUR_W-1:0] fund_mag,
    // Indicator reset switch
    input  wire logic                                       ind_reset_pin,
    // Element outputs
    output logic      [tdp_pkg::PHASES-1:0]                 bias_trip,
    output logic      [tdp_pkg::PHASES-1:0]                 doc_trip,
    output logic      [tdp_pkg::PHASES-1:0]                 second_harmonic_block,
    // Indicator lamps
    output logic                                            led_bias,
    output logic                                            led_doc,
    output logic                                            led_harm,
    output logic                                            led_yellow
);
    localparam int P  = tdp_pkg::PHASES;
    localparam int SW = tdp_pkg::SCL_W;
    localparam int PW = tdp_pkg::PRD_W;

    // Settings
    logic [1:0]               min_operate_setting_q;
    logic [1:0]               bias_sel_q;
    logic                     auto_q;
    logic                     irst_q;
    logic [tdp_pkg::SET_W-1:0] hv_match_tap_q;
    logic [tdp_pkg::SET_W-1:0] lv_match_tap_q;
    logic [tdp_pkg::SET_W-1:0] rated_q;
    logic [tdp_pkg::SET_W-1:0] doc_set_q;
    logic [tdp_pkg::SET_W-1:0] harm_ratio_q;

    // Pipeline
    logic                     valid1_q;
    logic [P-1:0][SW-1:0]     hv_scl_q;
    logic [P-1:0][SW-1:0]     lv_scl_q;
    logic [P-1:0][SW-1:0]     hv_scl_d;
    logic [P-1:0][SW-1:0]     lv_scl_d;
    logic [P-1:0]             harm_s1_q;
    logic [P-1:0]             harm_s1_d;
    logic [P-1:0]             bias_raw_q;
    logic [P-1:0]             bias_raw_d;
    logic [P-1:0]             doc_q;
    logic [P-1:0]             doc_d;
    logic [P-1:0]             harm_q;
    logic [P-1:0]             lz_q;
    logic [P-1:0]             lz_d;
    logic                     all_lock;
    logic [P-1:0]             blk_d;
    logic [P-1:0]             bias_trip_d;
    logic [6:0]               minop_pct;
    logic [6:0]               bias_pct;

    // Indication and history
    logic                     irst_sync1_q;
    logic                     irst_sync2_q;
    logic                     clr;
    logic [3:0]               cur_ind;
    logic [3:0]               lat_q;
    logic [3:0]               lat_d;
    logic [tdp_pkg::BLINK_W-1:0] blink_cnt_q;
    logic                     blink_q;
    tdp_pkg::tdp_restore_e    rs_q;
    logic                     ind_we;
    logic [tdp_pkg::HIST_W-1:0] ind_rd;
    logic                     trip_any_q;
    logic                     trip_any_d;
    logic                     hist_evt;
    logic [tdp_pkg::HIST_W-1:0] hist_rd;
    logic [2:0]               hist_idx;

    // APB
    logic                     acc;
    logic                     wr_en;
    logic                     mapped;
    logic [31:0]              rdata_d;

    assign minop_pct = tdp_pkg::tdp_sel_pct(min_operate_setting_q);
    assign bias_pct  = tdp_pkg::tdp_sel_pct(bias_sel_q);

    always_comb begin
        for (int p = 0; p < P; p++) begin
            hv_scl_d[p] = ({8'h00, hv_secondary_current[p]} * {16'h0000, rated_q})
                          / {16'h0000, (hv_match_tap_q == '0) ? 8'h01 : hv_match_tap_q};
            lv_scl_d[p] = ({8'h00, lv_secondary_current[p]} * {16'h0000, rated_q})
                          / {16'h0000, (lv_match_tap_q == '0) ? 8'h01 : lv_match_tap_q};
            harm_s1_d[p] = ({16'h0000, harm2_mag[p]} * 32'(tdp_pkg::PCT_FULL))
                           > ({16'h0000, fund_mag[p]} * 32'(harm_ratio_q));
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            valid1_q  <= 1'b0;
            hv_scl_q  <= '0;
            lv_scl_q  <= '0;
            harm_s1_q <= '0;
        end else begin
            valid1_q <= sample_valid;
            if (sample_valid) begin
                hv_scl_q  <= hv_scl_d;
                lv_scl_q  <= lv_scl_d;
                harm_s1_q <= harm_s1_d;
            end
        end
    end

    always_comb begin
        for (int p = 0; p < P; p++) begin
            logic [SW:0]   diff;
            logic [SW-1:0] res;
            logic [SW-1:0] load;
            logic [PW-1:0] diff100;
            diff    = '0;
            res     = '0;
            load    = '0;
            diff100 = '0;
            diff    = {1'b0, hv_scl_q[p]} - {1'b0, lv_scl_q[p]};
            res     = (hv_scl_q[p] > lv_scl_q[p]) ? hv_scl_q[p] : lv_scl_q[p];
            load    = (hv_scl_q[p] > lv_scl_q[p]) ? lv_scl_q[p] : hv_scl_q[p];
            diff100 = {8'h00, diff[SW-1:0]} * 32'(tdp_pkg::PCT_FULL);
            bias_raw_d[p] = !diff[SW]
                && (diff100 >= {8'h00, res} * 32'(bias_pct))
                && (diff100 >= 32'(rated_q) * 32'(minop_pct));
            doc_d[p] = !diff[SW] && ({8'h00, diff[SW-1:0]} * 32'(tdp_pkg::DOC_DIV)
                       > 32'(rated_q) * 32'(doc_set_q));
            // near zero below half the setting
            lz_d[p] = {8'h00, load} * 32'(tdp_pkg::PCT_HALF)
                      < 32'(rated_q) * 32'(minop_pct);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bias_raw_q <= '0;
            doc_q      <= '0;
            harm_q     <= '0;
            lz_q       <= '0;
        end else if (valid1_q) begin
            bias_raw_q <= bias_raw_d;
            doc_q      <= doc_d;
            harm_q     <= harm_s1_q;
            lz_q       <= lz_d;
        end
    end

    assign all_lock    = |(bias_raw_q & lz_q);
    assign blk_d       = all_lock ? {P{|harm_q}} : harm_q;
    assign bias_trip_d = bias_raw_q & ~blk_d;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bias_trip             <= '0;
            doc_trip              <= '0;
            second_harmonic_block <= '0;
        end else begin
            bias_trip             <= bias_trip_d;
            // not gated by the biased element
            doc_trip              <= doc_q;
            second_harmonic_block <= blk_d;
        end
    end

    // Indicator reset switch synchroniser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irst_sync1_q <= 1'b0;
            irst_sync2_q <= 1'b0;
        end else begin
            irst_sync1_q <= ind_reset_pin;
            irst_sync2_q <= irst_sync1_q;
        end
    end

    assign clr     = irst_sync2_q | irst_q;
    assign cur_ind = {|(harm_q & bias_raw_q), |harm_q, |doc_q, |bias_trip_d};
    // hold or follow, set wins over clear
    assign lat_d   = auto_q ? cur_ind : (cur_ind | (lat_q & ~{4{clr}}));

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
        end else if (blink_cnt_q == tdp_pkg::BLINK_W'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= !blink_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rs_q <= tdp_pkg::RS_WAIT;
        end else begin
            case (rs_q)
                tdp_pkg::RS_WAIT: rs_q <= tdp_pkg::RS_LOAD;
                tdp_pkg::RS_LOAD: rs_q <= tdp_pkg::RS_RUN;
                tdp_pkg::RS_RUN:  rs_q <= tdp_pkg::RS_RUN;
                default:          rs_q <= tdp_pkg::RS_WAIT;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lat_q      <= '0;
            led_harm   <= 1'b0;
        end else begin
            if (rs_q == tdp_pkg::RS_LOAD && !auto_q) begin
                lat_q <= lat_d | ind_rd[tdp_pkg::IND_W-1:0];
            end else begin
                lat_q <= lat_d;
            end
            led_harm <= lat_d[2] & blink_q;
        end
    end

    assign led_bias   = lat_q[0];
    assign led_doc    = lat_q[1];
    assign led_yellow = lat_q[3];

    assign ind_we     = (rs_q == tdp_pkg::RS_RUN) && !auto_q && (lat_d != lat_q);
    assign trip_any_d = |bias_trip_d | |doc_q;
    // new record on each fresh trip
    assign hist_evt   = trip_any_d & !trip_any_q;
    assign hist_idx   = 3'(8'(paddr - tdp_pkg::HIST_OFS) >> 2);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            trip_any_q <= 1'b0;
        end else begin
            trip_any_q <= trip_any_d;
        end
    end

    tdp_hist_mem u_mem (
        .clock       (clock),
        .shift_en    (hist_evt),
        .shift_data  ({7'h00, harm_q, doc_q, bias_trip_d}),
        .ind_we      (ind_we),
        .ind_data    ({12'h000, lat_d}),
        .ind_rd_data (ind_rd),
        .rd_idx      (hist_idx),
        .rd_data     (hist_rd)
    );

    // APB: one wait state, write and read at the pready edge
    assign acc    = psel & penable & !pready;
    assign wr_en  = psel & penable & pready & pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= tdp_pkg::HIST_END);

    always_comb begin
        rdata_d = '0;
        case (paddr)
            tdp_pkg::CTRL_OFS:   rdata_d = {26'h0, 1'b0, auto_q, bias_sel_q,
                                            min_operate_setting_q};
            tdp_pkg::TAP_OFS:    rdata_d = {16'h0, lv_match_tap_q, hv_match_tap_q};
            tdp_pkg::RATED_OFS:  rdata_d = {16'h0, doc_set_q, rated_q};
            tdp_pkg::HARM_OFS:   rdata_d = {24'h0, harm_ratio_q};
            tdp_pkg::STATUS_OFS: rdata_d = {22'h0, all_lock, harm_q, doc_q, bias_raw_q};
            tdp_pkg::LED_OFS:    rdata_d = {28'h0, lat_q};
            default:             rdata_d = (paddr >= tdp_pkg::HIST_OFS && mapped)
                                           ? {16'h0, hist_rd} : 32'h0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= acc;
            pslverr <= acc & !mapped;
            if (acc && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            min_operate_setting_q <= tdp_pkg::MINOP_RST;
            bias_sel_q            <= tdp_pkg::BIAS_RST;
            auto_q                <= tdp_pkg::AUTO_RST;
            irst_q                <= 1'b0;
            hv_match_tap_q        <= tdp_pkg::TAP_RST;
            lv_match_tap_q        <= tdp_pkg::TAP_RST;
            rated_q               <= tdp_pkg::RATED_RST;
            doc_set_q             <= tdp_pkg::DOC_RST;
            harm_ratio_q          <= tdp_pkg::HARM_RST;
        end else begin
            irst_q <= wr_en && paddr == tdp_pkg::CTRL_OFS && pwdata[tdp_pkg::IRST_BIT];
            if (wr_en) begin
                case (paddr)
                    tdp_pkg::CTRL_OFS: begin
                        min_operate_setting_q <= pwdata[tdp_pkg::MINOP_LSB +: 2];
                        bias_sel_q            <= pwdata[tdp_pkg::BIAS_LSB +: 2];
                        auto_q                <= pwdata[tdp_pkg::AUTO_BIT];
                    end
                    tdp_pkg::TAP_OFS: begin
                        hv_match_tap_q <= pwdata[0 +: tdp_pkg::SET_W];
                        lv_match_tap_q <= pwdata[tdp_pkg::LV_LSB +: tdp_pkg::SET_W];
                    end
                    tdp_pkg::RATED_OFS: begin
                        rated_q   <= pwdata[0 +: tdp_pkg::SET_W];
                        doc_set_q <= pwdata[tdp_pkg::DOC_LSB +: tdp_pkg::SET_W];
                    end
                    tdp_pkg::HARM_OFS: harm_ratio_q <= pwdata[0 +: tdp_pkg::SET_W];
                    default: ;
                endcase
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    scale_equal_a: assert property (sample_valid && hv_match_tap_q == rated_q
        |=> hv_scl_q[0] == {8'h00, $past(hv_secondary_current[0])})
        else $error("hv scaling wrong when tap equals rated current");
    diff_sign_a: assert property (valid1_q && lv_scl_q[0] >= hv_scl_q[0]
        |=> !bias_raw_q[0] && !doc_q[0])
        else $error("differential element operated with low side larger");
    bias_ratio_a: assert property (valid1_q && lv_scl_q[0] == '0
        && {8'h00, hv_scl_q[0]} * 32'(tdp_pkg::PCT_FULL) >= 32'(rated_q) * 32'(minop_pct)
        |=> bias_raw_q[0])
        else $error("full ratio above minimum did not operate");
    min_operate_setting_a: assert property (valid1_q && lv_scl_q[0] == '0
        && {8'h00, hv_scl_q[0]} * 32'(tdp_pkg::PCT_FULL) < 32'(rated_q) * 32'(minop_pct)
        |=> !bias_raw_q[0])
        else $error("biased element operated below minimum");
    harm_block_a: assert property (second_harmonic_block[1] |-> !bias_trip[1])
        else $error("biased trip while harmonic blocked");
    all_lock_a: assert property (all_lock && |harm_q |=> bias_trip == '0)
        else $error("all-phase lock let a biased trip through");
    seg_lock_a: assert property (!all_lock && !harm_q[0] && bias_raw_q[0]
        |=> bias_trip[0])
        else $error("segregated lock blocked a clean phase");
    doc_fast_a: assert property (doc_q[2] |=> doc_trip[2])
        else $error("overcurrent trip delayed");
    led_on_a: assert property (|bias_trip_d |=> led_bias)
        else $error("bias lamp not lit at once");
    yellow_lamp_a: assert property (|(harm_q & bias_raw_q) |=> led_yellow)
        else $error("yellow lamp missing");
    hold_lamp_a: assert property (!auto_q && led_doc && !clr |=> led_doc)
        else $error("held lamp dropped without reset");
    clear_lamp_a: assert property (clr && !auto_q && !(|doc_q)
        && rs_q == tdp_pkg::RS_RUN |=> !led_doc)
        else $error("indicator reset did not clear");

    bias_trip_c: cover property (|bias_trip);
    doc_trip_c: cover property (|doc_trip);
    all_lock_c: cover property (all_lock && |harm_q);
    blink_c: cover property (led_harm ##1 !led_harm);
endmodule // tdp_top

// file: tb/tdp_meas_model.sv
// Front end model: hands one sample of every phase to the block
`timescale 1ns/100ps
module tdp_meas_model (
    // Clock
    input  wire logic       clock,
    // Sample outputs
    output logic             sample_valid,
    output logic [2:0][15:0] hv_secondary_current,
    output logic [2:0][15:0] lv_secondary_current,
    output logic [2:0][15:0] harm2_mag,
    output logic [2:0][15:0] fund_mag
);
    initial begin
        sample_valid = 1'b0;
        {hv_secondary_current, lv_secondary_current, harm2_mag, fund_mag} = '0;
    end
    // Held values lapse to their inverse once taken, then outputs settle
    task automatic send(input logic [191:0] v);
        @(posedge clock);
        sample_valid <= 1'b1;
        {hv_secondary_current, lv_secondary_current, harm2_mag, fund_mag} <= v;
        @(posedge clock);
        sample_valid <= 1'b0;
        {hv_secondary_current, lv_secondary_current, harm2_mag, fund_mag} <= ~v;
        repeat (3) @(posedge clock);
        #1;
    endtask
endmodule // tdp_meas_model

// file: tb/tb_tdp_top.sv
// Bench: register access, element decisions, lamps and fault history
`timescale 1ns/100ps
module tb_tdp_top;
    localparam logic [47:0] Z = 48'h0;
    localparam logic [31:0] RV [4] = '{32'h09, 32'h3232, 32'h5032, 32'h0f};
    localparam logic [31:0] HX [2] = '{32'h3f, 32'h1};
    logic             clock, rst, psel, penable, pwrite, pready, pslverr, e, ind_reset_pin;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, q;
    logic             sample_valid, led_bias, led_doc, led_harm, led_yellow;
    logic [2:0][15:0] hv_secondary_current, lv_secondary_current, harm2_mag, fund_mag;
    logic [2:0]       bias_trip, doc_trip, second_harmonic_block;
    logic [15:0]      p;
    int               err_count, n_compared, cycles;
    tdp_top #(.BLINK_CYC(4)) u_tdp_top (.clock, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sample_valid, .hv_secondary_current,
        .lv_secondary_current, .harm2_mag, .fund_mag, .ind_reset_pin, .bias_trip,
        .doc_trip, .second_harmonic_block, .led_bias, .led_doc, .led_harm, .led_yellow);
    tdp_meas_model u_tdp_meas_model (.clock, .sample_valid, .hv_secondary_current,
        .lv_secondary_current, .harm2_mag, .fund_mag);
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    // One transfer after an idle cycle; q and e take the answer at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {psel, pwrite} <= {1'b1, w};
        {paddr, pwdata} <= {a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b0;
    endtask
    task automatic smp(input logic [191:0] v);
        u_tdp_meas_model.send(v);
    endtask
    task automatic wrap_up();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, ind_reset_pin} = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (RV[i]) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", RV[i], q);
        end
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, q);
        // Each setting code at its boundary; phase 2 flows backwards
        for (int i = 0; i < 3; i++) begin
            p = 16'(20 + 10 * i);
            apb(1'b1, 8'h00, 32'(8 + i));
            smp({16'h0, 16'(p / 2 - 1), 16'(p / 2), 16'h64, 32'h0, {2{Z}}});
            chk("min operate", 32'h1, 32'(bias_trip));
            apb(1'b1, 8'h00, 32'(1 + 4 * i));
            smp({16'h0, {2{16'h64}}, 16'h64, 16'(101 - p), 16'(100 - p), {2{Z}}});
            chk("bias ratio", 32'h1, 32'(bias_trip));
        end
        apb(1'b1, 8'h04, 32'h3219);
        smp({16'h0, 16'h7, 16'ha, {3{Z}}});
        chk("scaled trip", 32'h1, 32'(bias_trip));
        apb(1'b1, 8'h04, 32'h3232);
        smp(192'h0);
        chk("trip released", 32'h0, 32'(bias_trip));
        chk("held lamp", 32'h1, 32'(led_bias));
        smp({{3{16'h1f4}}, {3{Z}}});
        chk("overcurrent", 32'h7, 32'(doc_trip));
        chk("doc lamp", 32'h1, 32'(led_doc));
        smp(192'h0);
        foreach (HX[i]) begin
            apb(1'b0, 8'(24 + 4 * i), 32'h0);
            chk("history", HX[i], q);
        end
        smp({16'h0, {2{16'h64}}, Z, 32'h0, 16'h14, {3{16'h64}}});
        chk("all lock", 32'h7, 32'(second_harmonic_block));
        chk("blocked trip", 32'h0, 32'(bias_trip));
        chk("yellow", 32'h1, 32'(led_yellow));
        // Held harmonic lamp is high for half of any eight cycles
        repeat (8) begin
            @(posedge clock);
            q = {q[30:0], led_harm};
        end
        chk("harm blink", 32'h4, 32'($countones(q[7:0])));
        smp({16'h0, {2{16'h64}}, 16'h0, {2{16'h32}}, 32'h0, 16'h14, {3{16'h64}}});
        chk("own lock", 32'h1, 32'(second_harmonic_block));
        chk("free phase", 32'h2, 32'(bias_trip));
        // Reset in mid-run; held lamps come back from the retained store
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("restored lamps", 32'h7, 32'({led_bias, led_doc, led_yellow}));
        smp(192'h0);
        apb(1'b1, 8'h00, 32'h29);
        repeat (2) @(posedge clock);
        #1;
        chk("cleared lamps", 32'h0, 32'({led_bias, led_doc, led_yellow}));
        smp({{3{16'h1f4}}, {3{Z}}});
        smp(192'h0);
        @(posedge clock);
        ind_reset_pin <= 1'b1;
        repeat (4) @(posedge clock);
        ind_reset_pin <= 1'b0;
        #1;
        chk("pin cleared", 32'h0, 32'({led_bias, led_doc, led_yellow}));
        apb(1'b1, 8'h00, 32'h19);
        smp({32'h0, 16'h64, {3{Z}}});
        chk("auto lamp on", 32'h1, 32'(led_bias));
        smp(192'h0);
        chk("auto lamp off", 32'h0, 32'(led_bias));
        wrap_up();
    end
endmodule // tb_tdp_top
